/* logic/qbuf_pkg.sv */
package qbuf_pkg;

  // ----------------------------------------------------------------
  // Register offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] A_CTRL   = 8'h00;
  localparam logic [7:0] A_QEN    = 8'h04;
  localparam logic [7:0] A_QIN    = 8'h08;
  localparam logic [7:0] A_QOUT   = 8'h0c;
  localparam logic [7:0] A_WATER  = 8'h10;
  localparam logic [7:0] A_AFULL  = 8'h14;
  localparam logic [7:0] A_AEMPTY = 8'h18;
  localparam logic [7:0] A_TARGET = 8'h1c;
  localparam logic [7:0] A_MCAST  = 8'h20;
  localparam logic [7:0] A_DUP    = 8'h24;
  localparam logic [7:0] A_FLAGS  = 8'h28;
  localparam logic [7:0] A_ISTAT  = 8'h2c;
  localparam logic [7:0] A_IMASK  = 8'h30;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int CTRL_ACTIVE = 0;
  localparam int CTRL_MASTER = 1;
  localparam int CTRL_BYTES  = 2;
  localparam int EV_WATER    = 0;
  localparam int EV_DROP     = 1;
  localparam int EV_DB       = 2;
  localparam int HDR_DEST    = 24;
  localparam int HDR_SRC     = 16;
  localparam int HDR_FT      = 12;
  localparam int PA_FT       = 3;
  localparam int PA_DEST     = 7;
  localparam int PA_W        = 15;
  localparam int BYTE_SH     = 2;

  // ----------------------------------------------------------------
  // Reset values and codes
  // ----------------------------------------------------------------
  localparam logic [2:0]  RST_CTRL   = 3'h0;
  localparam logic [15:0] RST_WATER  = 16'h0010;
  localparam logic [15:0] RST_AFULL  = 16'h00f0;
  localparam logic [15:0] RST_AEMPTY = 16'h0004;
  localparam logic [3:0]  FT_SWRITE  = 4'h6;
  localparam logic [1:0]  PORT_S1    = 2'h0;
  localparam logic [1:0]  PORT_S2    = 2'h1;
  localparam logic [1:0]  PORT_PAR   = 2'h2;

  typedef enum logic [1:0] {ST_IDLE, ST_SEND} tx_state_t;
  typedef enum logic [1:0] {K_PLAIN, K_MCAST, K_SWRITE} send_kind_t;

endpackage

/* logic/queue_buffer_device.sv */
`timescale 1ns/10ps
// ------------------------------------------------------------------
// ------------------------------------------------------------------
module queue_buffer_device
  import qbuf_pkg::*;
#(
  parameter int         NQ     = 8,
  parameter int         DEPTH  = 256,
  parameter int         DW     = 32,
  // Arbitrary value
  parameter logic [7:0] OWN_ID = 8'h3c
)(
  // Clock and reset
  input  wire logic                   clk_i,
  input  wire logic                   rst_i,
  input  wire logic                   ce_i,
  // Wishbone slave
  input  wire logic                   wb_cyc_i,
  input  wire logic                   wb_stb_i,
  input  wire logic                   wb_we_i,
  input  wire logic [7:0]             wb_adr_i,
  input  wire logic [3:0]             wb_sel_i,
  input  wire logic [31:0]            wb_dat_i,
  output logic      [31:0]            wb_dat_o,
  output logic                        wb_ack_o,
  // Ingress packets
  input  wire logic                   in_valid_i,
  input  wire logic [DW-1:0]          in_data_i,
  input  wire logic                   in_last_i,
  input  wire logic [1:0]             in_port_i,
  input  wire logic [$clog2(NQ)-1:0]  in_queue_i,
  input  wire logic [PA_W-1:0]        par_addr_i,
  output logic                        in_ready_o,
  // Doorbells
  input  wire logic                   db_valid_i,
  input  wire logic [$clog2(NQ)-1:0]  db_queue_i,
  // Link status
  input  wire logic                   stat_req_i,
  output logic                        stat_ack_o,
  output logic      [31:0]            stat_data_o,
  // Egress packets
  output logic                        out_valid_o,
  output logic      [DW-1:0]          out_data_o,
  output logic                        out_last_o,
  output logic      [1:0]             out_port_o,
  input  wire logic                   out_ready_i,
  // Flags
  output logic      [NQ-1:0]          pkt_rdy_o,
  output logic                        full_o,
  output logic                        empty_o,
  output logic                        afull_o,
  output logic                        aempty_o,
  output logic                        rcpt_o,
  output logic                        irq_o
);
  localparam int QW = $clog2(NQ);
  localparam int CW = $clog2(DEPTH) + 1;

  typedef struct packed {
    logic [2:0]      ctrl;
    logic [NQ-1:0]   qen;
    logic [2*NQ-1:0] qin;
    logic [2*NQ-1:0] qout;
    logic [15:0]     water;
    logic [15:0]     afull;
    logic [15:0]     aempty;
    logic [31:0]     target;
    logic [7:0]      mcast;
    logic [3:0]      dup;
    logic [2:0]      ist;
    logic [2:0]      imask;
    logic            ack;
    logic [31:0]     rdat;
    tx_state_t       st;
    send_kind_t      kind;
    logic [QW-1:0]   tq;
    logic [1:0]      widx;
    logic            ov;
    logic [DW-1:0]   odata;
    logic            olast;
    logic [1:0]      oport;
    logic [NQ-1:0]   armed;
    logic [NQ-1:0]   dbp;
    logic            first;
    logic [QW-1:0]   wsel;
    logic            rdy;
    logic            rcpt;
    logic            sack;
    logic [31:0]     sdata;
    logic [NQ-1:0]   prdy;
    logic            full;
    logic            empty;
    logic            af;
    logic            ae;
    logic            irq;
  } state_t;

  state_t          s_q;
  state_t          s_d;
  logic [NQ-1:0]   q_wr;
  logic [NQ-1:0]   q_rd;
  logic [DW-1:0]   wdata;
  logic [DW-1:0]   rdat   [NQ];
  logic [NQ-1:0]   rlast;
  logic [CW-1:0]   words  [NQ];
  logic [CW-1:0]   pkts   [NQ];
  logic [NQ-1:0]   qfull;
  logic [NQ-1:0]   qroom;

  // ----------------------------------------------------------------
  // Queue slots
  // ----------------------------------------------------------------
  queue_if #(.DW(DW), .CW(CW)) qif [NQ] ();

  for (genvar g = 0; g < NQ; g++)
  begin : g_q
    queue_slot #(.DW(DW), .DEPTH(DEPTH)) u_slot (
      .clk_i (clk_i),
      .rst_i (rst_i),
      .ce_i  (ce_i),
      .qp    (qif[g].slot)
    );
    assign qif[g].wr_en   = q_wr[g];
    assign qif[g].wr_last = in_last_i;
    assign qif[g].wr_data = wdata;
    assign qif[g].rd_en   = q_rd[g];
    assign rdat[g]        = qif[g].rd_data;
    assign rlast[g]       = qif[g].rd_last;
    assign words[g]       = qif[g].words;
    assign pkts[g]        = qif[g].pkts;
    assign qfull[g]       = qif[g].full;
    assign qroom[g]       = qif[g].room;
  end

  function automatic logic [31:0] bmask(input logic [31:0] o, input logic [31:0] n, input logic [3:0] sel);
    logic [31:0] m;
    m = {{8{sel[3]}}, {8{sel[2]}}, {8{sel[1]}}, {8{sel[0]}}};
    return (o & ~m) | (n & m);
  endfunction

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb
  begin
    logic            wr;
    logic [2:0]      ev;
    logic [QW-1:0]   qsel;
    logic [NQ-1:0]   tgt;
    logic [NQ-1:0]   ok;
    logic [15:0]     occ;
    logic            found;
    logic            hit;
    logic [QW-1:0]   cq;
    send_kind_t      ck;
    logic [DW-1:0]   w;
    wr    = 1'b0;
    ev    = '0;
    qsel  = '0;
    tgt   = '0;
    ok    = '0;
    occ   = '0;
    found = 1'b0;
    hit   = 1'b0;
    cq    = '0;
    ck    = K_PLAIN;
    w     = '0;
    s_d   = s_q;
    q_wr  = '0;
    q_rd  = '0;
    wdata = in_data_i;

    // Bus slave, one wait state
    s_d.ack  = wb_cyc_i & wb_stb_i & ~s_q.ack;
    wr       = s_q.ack & wb_cyc_i & wb_stb_i & wb_we_i;
    s_d.rdat = '0;
    if (s_d.ack && !wb_we_i)
    begin
      case (wb_adr_i)
        A_CTRL:   s_d.rdat = 32'(s_q.ctrl);
        A_QEN:    s_d.rdat = 32'(s_q.qen);
        A_QIN:    s_d.rdat = 32'(s_q.qin);
        A_QOUT:   s_d.rdat = 32'(s_q.qout);
        A_WATER:  s_d.rdat = 32'(s_q.water);
        A_AFULL:  s_d.rdat = 32'(s_q.afull);
        A_AEMPTY: s_d.rdat = 32'(s_q.aempty);
        A_TARGET: s_d.rdat = s_q.target;
        A_MCAST:  s_d.rdat = 32'(s_q.mcast);
        A_DUP:    s_d.rdat = 32'(s_q.dup);
        A_FLAGS:  s_d.rdat = {12'h000, s_q.ae, s_q.af, s_q.empty, s_q.full, 8'h00, 8'(s_q.prdy)};
        A_ISTAT:  s_d.rdat = 32'(s_q.ist);
        A_IMASK:  s_d.rdat = 32'(s_q.imask);
        default:  s_d.rdat = '0;
      endcase
    end
    if (wr)
    begin
      case (wb_adr_i)
        A_CTRL:   s_d.ctrl   = 3'(bmask(32'(s_q.ctrl), wb_dat_i, wb_sel_i));
        A_QEN:    s_d.qen    = NQ'(bmask(32'(s_q.qen), wb_dat_i, wb_sel_i));
        A_QIN:    s_d.qin    = (2*NQ)'(bmask(32'(s_q.qin), wb_dat_i, wb_sel_i));
        A_QOUT:   s_d.qout   = (2*NQ)'(bmask(32'(s_q.qout), wb_dat_i, wb_sel_i));
        A_WATER:  s_d.water  = 16'(bmask(32'(s_q.water), wb_dat_i, wb_sel_i));
        A_AFULL:  s_d.afull  = 16'(bmask(32'(s_q.afull), wb_dat_i, wb_sel_i));
        A_AEMPTY: s_d.aempty = 16'(bmask(32'(s_q.aempty), wb_dat_i, wb_sel_i));
        A_TARGET: s_d.target = bmask(s_q.target, wb_dat_i, wb_sel_i);
        A_MCAST:  s_d.mcast  = 8'(bmask(32'(s_q.mcast), wb_dat_i, wb_sel_i));
        A_DUP:    s_d.dup    = 4'(bmask(32'(s_q.dup), wb_dat_i, wb_sel_i));
        A_IMASK:  s_d.imask  = 3'(bmask(32'(s_q.imask), wb_dat_i, wb_sel_i));
        default:  s_d.ctrl   = s_q.ctrl;
      endcase
    end

    qsel = (in_port_i == PORT_PAR) ? par_addr_i[QW-1:0] : in_queue_i;
    tgt[qsel] = 1'b1;
    // serial 1 copies into up to five queues
    if (in_port_i == PORT_S1)
      tgt[3:0] = tgt[3:0] | s_q.dup;
    for (int q = 0; q < NQ; q++)
      ok[q] = tgt[q] & s_q.qen[q] & (s_q.qin[2*q +: 2] == in_port_i);
    if (in_port_i == PORT_PAR && s_q.first)
    begin
      wdata[HDR_DEST +: 8] = par_addr_i[PA_DEST +: 8];
      wdata[HDR_FT +: 4]   = par_addr_i[PA_FT +: 4];
    end
    s_d.rcpt = 1'b0;
    if (in_valid_i && s_q.rdy)
    begin
      q_wr       = ok;
      s_d.first  = in_last_i;
      s_d.wsel   = qsel;
      ev[EV_DROP] = |(tgt & ~ok);
      for (int q = 0; q < NQ; q++)
        if (ok[q] && in_last_i && in_port_i == PORT_S1 && s_q.qout[2*q +: 2] != PORT_S1)
          s_d.rcpt = 1'b1;
    end
    s_d.rdy = &(qroom | ~s_q.qen);

    // Egress word pump
    if (s_q.ov && out_ready_i)
      s_d.ov = 1'b0;
    if (s_q.st == ST_SEND && (!s_q.ov || out_ready_i))
    begin
      q_rd[s_q.tq] = 1'b1;
      w = rdat[s_q.tq];
      if (s_q.widx == 2'd0)
      begin
        if (s_q.kind == K_MCAST)
          w[HDR_DEST +: 8] = s_q.mcast;
        if (s_q.kind != K_PLAIN)
          w[HDR_FT +: 4] = FT_SWRITE;
        if (s_q.oport != s_q.qin[2*s_q.tq +: 2])
          w[HDR_SRC +: 8] = OWN_ID;
      end
      else if (s_q.widx == 2'd1 && s_q.kind != K_PLAIN)
        w = DW'(s_q.target);
      s_d.ov    = 1'b1;
      s_d.odata = w;
      s_d.olast = rlast[s_q.tq];
      if (s_q.widx != 2'd2)
        s_d.widx = s_q.widx + 2'd1;
      if (rlast[s_q.tq])
        s_d.st = ST_IDLE;
    end

    // Scheduler, lowest queue first
    for (int q = NQ-1; q >= 0; q--)
    begin
      occ = s_q.ctrl[CTRL_BYTES] ? 16'({words[q], BYTE_SH'(0)}) : 16'(pkts[q]);
      if (occ < s_q.water)
        s_d.armed[q] = 1'b1;
      if (s_q.qen[q] && pkts[q] != '0)
      begin
        hit = 1'b1;
        if (s_q.dbp[q])
          ck = K_PLAIN;
        else if (s_q.ctrl[CTRL_MASTER] && s_q.armed[q] && occ >= s_q.water)
          ck = K_MCAST;
        else if (s_q.ctrl[CTRL_MASTER] && 16'(words[q]) >= s_q.afull)
          ck = K_SWRITE;
        else if (s_q.ctrl[CTRL_ACTIVE])
          ck = K_PLAIN;
        else
          hit = 1'b0;
        if (hit)
        begin
          found = 1'b1;
          cq    = QW'(q);
        end
      end
    end
    case (s_q.st)
      ST_IDLE:
      begin
        if (found && !s_d.ov)
        begin
          s_d.st    = ST_SEND;
          s_d.tq    = cq;
          s_d.kind  = ck;
          s_d.widx  = 2'd0;
          s_d.oport = (ck == K_MCAST) ? PORT_S1 : s_q.qout[2*cq +: 2];
          if (s_q.dbp[cq])
          begin
            s_d.dbp[cq] = 1'b0;
            ev[EV_DB]   = 1'b1;
          end
          if (ck == K_MCAST)
          begin
            s_d.armed[cq] = 1'b0;
            ev[EV_WATER]  = 1'b1;
          end
        end
      end
      ST_SEND:
        s_d.st = s_d.st;
      default:
        s_d.st = ST_IDLE;
    endcase
    if (db_valid_i)
      s_d.dbp[db_queue_i] = 1'b1;

    s_d.sack  = stat_req_i;
    s_d.sdata = stat_req_i ? {12'h000, s_q.ae, s_q.af, s_q.empty, s_q.full, 8'h00, 8'(s_q.prdy)} : s_q.sdata;

    for (int q = 0; q < NQ; q++)
      s_d.prdy[q] = s_q.qen[q] & (pkts[q] != '0);
    s_d.full  = qfull[s_d.wsel];
    s_d.af    = 16'(words[s_d.wsel]) >= s_q.afull;
    s_d.empty = pkts[s_d.tq] == '0;
    s_d.ae    = 16'(words[s_d.tq]) <= s_q.aempty;

    // Interrupt status, set wins
    s_d.ist = (wr && wb_adr_i == A_ISTAT) ? (s_q.ist & ~(wb_dat_i[2:0] & {3{wb_sel_i[0]}})) : s_q.ist;
    s_d.ist = s_d.ist | ev;
    s_d.irq = |(s_d.ist & s_d.imask);
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      s_q        <= '0;
      s_q.ctrl   <= RST_CTRL;
      s_q.water  <= RST_WATER;
      s_q.afull  <= RST_AFULL;
      s_q.aempty <= RST_AEMPTY;
      s_q.armed  <= '1;
      s_q.first  <= 1'b1;
      s_q.empty  <= 1'b1;
    end
    else if (ce_i)
      s_q <= s_d;
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign wb_dat_o    = s_q.rdat;
  assign wb_ack_o    = s_q.ack;
  assign in_ready_o  = s_q.rdy;
  assign stat_ack_o  = s_q.sack;
  assign stat_data_o = s_q.sdata;
  assign out_valid_o = s_q.ov;
  assign out_data_o  = s_q.odata;
  assign out_last_o  = s_q.olast;
  assign out_port_o  = s_q.oport;
  assign pkt_rdy_o   = s_q.prdy;
  assign full_o      = s_q.full;
  assign empty_o     = s_q.empty;
  assign afull_o     = s_q.af;
  assign aempty_o    = s_q.ae;
  assign rcpt_o      = s_q.rcpt;
  assign irq_o       = s_q.irq;
endmodule

/* logic/queue_if.sv */
`timescale 1ns/10ps
interface queue_if #(
  parameter int DW = 32,
  parameter int CW = 9
);
  logic          wr_en;
  logic          wr_last;
  logic [DW-1:0] wr_data;
  logic          rd_en;
  logic [DW-1:0] rd_data;
  logic          rd_last;
  logic [CW-1:0] words;
  logic [CW-1:0] pkts;
  logic          full;
  logic          room;

  modport slot (input wr_en, wr_last, wr_data, rd_en,
                output rd_data, rd_last, words, pkts, full, room);
  modport ctrl (output wr_en, wr_last, wr_data, rd_en,
                input rd_data, rd_last, words, pkts, full, room);
endinterface

/* logic/queue_slot.sv */
`timescale 1ns/10ps
module queue_slot
  import qbuf_pkg::*;
#(
  parameter int DW    = 32,
  parameter int DEPTH = 256
)(
  // Clock and reset
  input  wire logic clk_i,
  input  wire logic rst_i,
  input  wire logic ce_i,
  // Queue port
  queue_if.slot     qp
);
  localparam int AW = $clog2(DEPTH);
  localparam logic [AW:0] DEPTH_C = (AW+1)'(DEPTH);
  localparam logic [AW:0] ROOM_C  = (AW+1)'(DEPTH - 2);

  typedef struct packed {
    logic [AW:0] wp;
    logic [AW:0] cwp;
    logic [AW:0] rp;
    logic [AW:0] pk;
  } slot_t;

  slot_t       s_q;
  slot_t       s_d;
  logic [DW:0] mem [DEPTH];
  logic [AW:0] fill;

  // ----------------------------------------------------------------
  // Pointers
  // ----------------------------------------------------------------
  always_comb
  begin
    s_d = s_q;
    if (qp.wr_en)
    begin
      s_d.wp = s_q.wp + 1'b1;
      if (qp.wr_last)
        s_d.cwp = s_d.wp;
    end
    if (qp.rd_en)
      s_d.rp = s_q.rp + 1'b1;
    s_d.pk = s_q.pk + (AW+1)'(qp.wr_en & qp.wr_last) - (AW+1)'(qp.rd_en & qp.rd_last);
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      s_q <= '0;
    else if (ce_i)
      s_q <= s_d;
  end

  always_ff @(posedge clk_i)
  begin
    if (ce_i && qp.wr_en)
      mem[s_q.wp[AW-1:0]] <= {qp.wr_last, qp.wr_data};
  end

  // ----------------------------------------------------------------
  // Status
  // ----------------------------------------------------------------
  assign fill       = s_q.wp - s_q.rp;
  assign qp.words   = s_q.cwp - s_q.rp;
  assign qp.pkts    = s_q.pk;
  assign qp.full    = (fill == DEPTH_C);
  assign qp.room    = (fill <= ROOM_C);
  assign qp.rd_data = mem[s_q.rp[AW-1:0]][DW-1:0];
  assign qp.rd_last = mem[s_q.rp[AW-1:0]][DW];
endmodule

/* sim/qbuf_sink.sv */
`timescale 1ns/10ps
// ----------------------------------------
// Egress sink, stalls two cycles in eight
// ----------------------------------------
module qbuf_sink (
  // Clock and reset
  input  wire logic clk_i,
  input  wire logic rst_i,
  // Stream
  input  wire logic out_valid_i,
  output logic      out_ready_o
);
  logic [2:0] cnt_q;
  logic       rdy_q;

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      cnt_q <= 3'h0;
      rdy_q <= 1'b0;
    end
    else
    begin
      cnt_q <= out_valid_i ? cnt_q + 3'h1 : cnt_q;
      rdy_q <= cnt_q[2:1] != 2'h1;
    end
  end

  assign out_ready_o = rdy_q;
endmodule

/* sim/queue_buffer_device_props.sv */
`timescale 1ns/10ps
// ----------------------------------------
// Port checker
// ----------------------------------------
module queue_buffer_device_props
  import qbuf_pkg::*;
#(
  parameter int NQ = 8,
  parameter int DW = 32
)(
  // Clock and reset
  input wire logic          clk_i,
  input wire logic          rst_i,
  input wire logic          ce_i,
  // Bus
  input wire logic          wb_cyc_i,
  input wire logic          wb_stb_i,
  input wire logic          wb_ack_o,
  // Ingress and status
  input wire logic          in_valid_i,
  input wire logic          in_last_i,
  input wire logic [1:0]    in_port_i,
  input wire logic          in_ready_o,
  input wire logic          stat_req_i,
  input wire logic          stat_ack_o,
  input wire logic          rcpt_o,
  // Egress and flags
  input wire logic          out_valid_o,
  input wire logic [DW-1:0] out_data_o,
  input wire logic          out_last_o,
  input wire logic [1:0]    out_port_o,
  input wire logic          out_ready_i,
  input wire logic [NQ-1:0] pkt_rdy_o,
  input wire logic          empty_o
);
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);

  sequence stall_s;
    out_valid_o && !out_ready_i && ce_i;
  endsequence

  sequence last_in_s;
    in_valid_i && in_ready_o && in_last_i && ce_i;
  endsequence

  wb_pulse_a: assert property (wb_ack_o && ce_i |=> !wb_ack_o)
    else $error("ack too long");
  wb_cause_a: assert property (wb_ack_o && $past(ce_i) |-> $past(wb_cyc_i && wb_stb_i && !wb_ack_o))
    else $error("ack without request");
  stat_answer_a: assert property (stat_req_i && ce_i |=> stat_ack_o)
    else $error("status not answered");
  stat_cause_a: assert property (stat_ack_o && $past(ce_i) |-> $past(stat_req_i))
    else $error("status ack without request");
  rcpt_cause_a: assert property (rcpt_o && $past(ce_i)
    |-> $past(in_valid_i && in_ready_o && in_last_i && in_port_i == PORT_S1))
    else $error("receipt without serial 1 packet");
  rcpt_skip_a: assert property (last_in_s ##0 in_port_i != PORT_S1 |=> !rcpt_o)
    else $error("receipt for other port");
  ready_gate_a: assert property ((pkt_rdy_o & ~$past(pkt_rdy_o)) != '0
    |-> $past(in_valid_i && in_ready_o && in_last_i, 2) || $past(wb_ack_o) || $past(wb_ack_o, 2))
    else $error("ready flag before whole packet");
  out_hold_a: assert property (stall_s |=> out_valid_o && $stable(out_data_o) && $stable(out_last_o)
    && $stable(out_port_o))
    else $error("egress word changed while stalled");
  reset_idle_a: assert property ($fell(rst_i) |-> empty_o && !out_valid_o && pkt_rdy_o == '0)
    else $error("outputs not idle after reset");
endmodule

bind queue_buffer_device queue_buffer_device_props #(.NQ(NQ), .DW(DW)) props_inst (
  .clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
  .wb_ack_o(wb_ack_o), .in_valid_i(in_valid_i), .in_last_i(in_last_i), .in_port_i(in_port_i),
  .in_ready_o(in_ready_o), .stat_req_i(stat_req_i), .stat_ack_o(stat_ack_o), .rcpt_o(rcpt_o),
  .out_valid_o(out_valid_o), .out_data_o(out_data_o), .out_last_o(out_last_o),
  .out_port_o(out_port_o), .out_ready_i(out_ready_i), .pkt_rdy_o(pkt_rdy_o), .empty_o(empty_o)
);

/* sim/queue_buffer_device_tb_top.sv */
`timescale 1ns/10ps
`define CHK(nm, e, s) \
  begin cmp_count++; if ((s) !== (e)) begin bad_count++; \
  $display("CHECK FAILED %s exp %h got %h", nm, e, s); end end
module queue_buffer_device_tb_top
  import qbuf_pkg::*;
;
  // Arbitrary value
  localparam logic [7:0] self_id = 8'h5a;
  localparam logic [7:0] mc_dest = 8'h77;
  logic        clk_i, rst_i, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, in_valid_i, in_last_i;
  logic        in_ready_o, db_valid_i, stat_req_i, stat_ack_o, out_valid_o, out_last_o;
  logic        out_ready_i, full_o, empty_o, afull_o, aempty_o, rcpt_o, irq_o;
  logic [7:0]  wb_adr_i, pkt_rdy_o;
  logic [31:0] wb_dat_i, wb_dat_o, in_data_i, stat_data_o, out_data_o, rs, tgt;
  logic [2:0]  in_queue_i, db_queue_i;
  logic [1:0]  in_port_i, out_port_o;
  logic [14:0] par_addr_i;
  logic [31:0] pw [3];
  logic [34:0] rd_q [$], out_q [$], ev;
  int          bad_count, cmp_count, rcpt_n, cyc_n;

  initial
  begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end

  queue_buffer_device #(.OWN_ID(self_id)) queue_buffer_device_inst (
    .clk_i(clk_i), .rst_i(rst_i), .ce_i(1'b1), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(4'hf), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o), .in_valid_i(in_valid_i), .in_data_i(in_data_i), .in_last_i(in_last_i),
    .in_port_i(in_port_i), .in_queue_i(in_queue_i), .par_addr_i(par_addr_i), .in_ready_o(in_ready_o),
    .db_valid_i(db_valid_i), .db_queue_i(db_queue_i), .stat_req_i(stat_req_i), .stat_ack_o(stat_ack_o),
    .stat_data_o(stat_data_o), .out_valid_o(out_valid_o), .out_data_o(out_data_o),
    .out_last_o(out_last_o), .out_port_o(out_port_o), .out_ready_i(out_ready_i), .pkt_rdy_o(pkt_rdy_o),
    .full_o(full_o), .empty_o(empty_o), .afull_o(afull_o), .aempty_o(aempty_o), .rcpt_o(rcpt_o),
    .irq_o(irq_o)
  );

  qbuf_sink qbuf_sink_inst (.clk_i(clk_i), .rst_i(rst_i), .out_valid_i(out_valid_o), .out_ready_o(out_ready_i));

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  task automatic tally_and_finish();
    $display("comparisons %0d mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  task automatic wb(input logic [7:0] a, input logic we, input logic [31:0] d);
    {wb_cyc_i, wb_stb_i, wb_we_i} <= {2'b11, we};
    wb_adr_i <= a;
    wb_dat_i <= d;
    do @(posedge clk_i); while (wb_ack_o !== 1'b1);
    {wb_cyc_i, wb_stb_i} <= 2'b00;
    @(posedge clk_i);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    rd_q.push_back({3'b000, e});
    wb(a, 1'b0, 32'h0);
  endtask

  task automatic gen();
    for (int i = 0; i < 3; i++)
    begin
      rs = lfsr(rs);
      pw[i] = rs;
    end
  endtask

  task automatic send(input logic [1:0] p, input logic [2:0] q);
    for (int i = 0; i < 3; i++)
    begin
      {in_valid_i, in_last_i} <= {1'b1, i == 2};
      in_data_i <= pw[i];
      {in_port_i, in_queue_i} <= {p, q};
      do @(posedge clk_i); while (in_ready_o !== 1'b1);
    end
    in_valid_i <= 1'b0;
    repeat (20) @(posedge clk_i);
  endtask

  task automatic expect_pkt(input logic [1:0] op, input logic sw, input logic mc);
    logic [31:0] w0, w1;
    w0 = pw[0];
    w1 = pw[1];
    if (sw)
      w0[HDR_SRC +: 8] = self_id;
    if (mc)
    begin
      w0[HDR_DEST +: 8] = mc_dest;
      w0[HDR_FT +: 4] = FT_SWRITE;
      w1 = tgt;
    end
    out_q.push_back({op, 1'b0, w0});
    out_q.push_back({op, 1'b0, w1});
    out_q.push_back({op, 1'b1, pw[2]});
  endtask

  task automatic drain();
    do @(posedge clk_i); while (out_q.size() != 0);
    repeat (10) @(posedge clk_i);
  endtask

  always @(posedge clk_i)
  begin
    cyc_n++;
    if (rcpt_o === 1'b1)
      rcpt_n++;
    if (wb_ack_o === 1'b1 && wb_we_i === 1'b0)
    begin
      ev = rd_q.size() != 0 ? rd_q.pop_front() : 'x;
      `CHK("read data", ev, {3'b000, wb_dat_o})
    end
    if (out_valid_o === 1'b1 && out_ready_i === 1'b1)
    begin
      ev = out_q.size() != 0 ? out_q.pop_front() : 'x;
      `CHK("egress word", ev, {out_port_o, out_last_o, out_data_o})
    end
    if (cyc_n > 20000)
    begin
      bad_count++;
      tally_and_finish();
    end
  end

  initial
  begin
    {rst_i, wb_cyc_i, wb_stb_i, wb_we_i, in_valid_i, in_last_i, db_valid_i, stat_req_i} = 8'h80;
    {wb_adr_i, wb_dat_i, in_data_i, in_port_i, in_queue_i, db_queue_i, par_addr_i} = '0;
    {bad_count, cmp_count, rcpt_n, cyc_n} = '0;
    rs = 32'h0000_0045;
    repeat (20) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    wb(A_FLAGS, 1'b1, 32'hffff_ffff);
    rd(A_FLAGS, 32'h000a_0000);
    rd(A_CTRL, 32'h0000_0000);
    rd(A_WATER, {16'h0000, RST_WATER});
    rd(A_AFULL, {16'h0000, RST_AFULL});
    rd(A_AEMPTY, {16'h0000, RST_AEMPTY});
    rd(8'hfc, 32'h0000_0000);
    wb(A_QEN, 1'b1, 32'h0000_0027);
    wb(A_QIN, 1'b1, 32'h0000_0010);
    wb(A_QOUT, 1'b1, 32'h0000_0400);
    wb(A_CTRL, 1'b1, 32'h0000_0001);
    gen();
    expect_pkt(PORT_S1, 1'b1, 1'b0);
    send(PORT_S2, 3'h2);
    drain();
    gen();
    expect_pkt(PORT_S2, 1'b1, 1'b0);
    send(PORT_S1, 3'h5);
    drain();
    wb(A_QIN, 1'b1, 32'h0000_0012);
    par_addr_i <= {mc_dest, 4'h5, 3'h0};
    gen();
    pw[0][HDR_DEST +: 8] = mc_dest;
    pw[0][HDR_FT +: 4] = 4'h5;
    expect_pkt(PORT_S1, 1'b1, 1'b0);
    pw[0] = pw[0] ^ 32'hff00_f000;
    send(PORT_PAR, 3'h0);
    drain();
    wb(A_QIN, 1'b1, 32'h0000_0010);
    `CHK("receipts", 1, rcpt_n)
    wb(A_IMASK, 1'b1, 32'h0000_0002);
    gen();
    send(PORT_S1, 3'h7);
    `CHK("irq set", 1'b1, irq_o)
    rd(A_ISTAT, 32'h0000_0002);
    wb(A_IMASK, 1'b1, 32'h0000_0000);
    @(posedge clk_i);
    `CHK("irq masked", 1'b0, irq_o)
    wb(A_ISTAT, 1'b1, 32'h0000_0002);
    rd(A_ISTAT, 32'h0000_0000);
    wb(A_CTRL, 1'b1, 32'h0000_0000);
    gen();
    send(PORT_S1, 3'h1);
    `CHK("ready flags", 8'h02, pkt_rdy_o)
    `CHK("queue flags", 4'b0011, {full_o, afull_o, empty_o, aempty_o})
    stat_req_i <= 1'b1;
    @(posedge clk_i);
    stat_req_i <= 1'b0;
    @(posedge clk_i);
    `CHK("status ack", 1'b1, stat_ack_o)
    `CHK("status flags", 8'h02, stat_data_o[7:0])
    expect_pkt(PORT_S1, 1'b0, 1'b0);
    for (int k = 0; k < 2; k++)
    begin
      {db_valid_i, db_queue_i} <= 4'h9;
      @(posedge clk_i);
      db_valid_i <= 1'b0;
      drain();
    end
    `CHK("ready cleared", 8'h00, pkt_rdy_o)
    rd(A_ISTAT, 32'h0000_0004);
    wb(A_ISTAT, 1'b1, 32'h0000_0007);
    rs = lfsr(rs);
    tgt = rs;
    wb(A_TARGET, 1'b1, tgt);
    wb(A_MCAST, 1'b1, {24'h000000, mc_dest});
    wb(A_WATER, 1'b1, 32'h0000_0018);
    wb(A_CTRL, 1'b1, 32'h0000_0006);
    gen();
    send(PORT_S1, 3'h0);
    expect_pkt(PORT_S1, 1'b0, 1'b1);
    gen();
    send(PORT_S1, 3'h0);
    drain();
    rd(A_ISTAT, 32'h0000_0001);
    `CHK("leftover", 0, out_q.size())
    tally_and_finish();
  end
endmodule
